// ===== rtl/pmpc_cfg.svh
// constants of the parallel master port control block
// assumes inclusion by the design files and the testbench
`ifndef PMPC_CFG_SVH
`define PMPC_CFG_SVH
// register byte offsets
`define PMPC_OFF_CTRL 12'h000
`define PMPC_OFF_RADDR 12'h004
`define PMPC_OFF_RDATA 12'h008
`define PMPC_OFF_WADDR 12'h00c
`define PMPC_OFF_WDATA 12'h010
// control field positions
`define PMPC_BIT_LAUNCH 23
`define PMPC_BIT_SPLIT 17
`define PMPC_BIT_ON 15
`define PMPC_BIT_IDLE 13
`define PMPC_MUX_HI 12
`define PMPC_MUX_LO 11
`define PMPC_BIT_TTL 10
`define PMPC_BIT_WREN 9
`define PMPC_BIT_RDEN 8
// writable bits of the control word
`define PMPC_CTRL_WMASK 32'h0002_bffb
`define PMPC_CTRL_RESET 32'h0000_0000
// strobe timing
`define PMPC_STROBE_NS 200
`define PMPC_CLK_NS 100
`define PMPC_STROBE_CYC ((`PMPC_STROBE_NS + `PMPC_CLK_NS - 1) / `PMPC_CLK_NS)
`endif

// ===== rtl/pmpc_pkg.sv
// types of the parallel master port control block
// assumes the cfg header is on the include path
package pmpc_pkg;
  typedef enum logic [1:0] {
    PMPC_MUX_NONE = 2'h0,
    PMPC_MUX_LOW8 = 2'h1,
    PMPC_MUX_ALL16 = 2'h2,
    PMPC_MUX_LOW8_WIDE = 2'h3
  } pmpc_mux_t;
  typedef enum logic [3:0] {
    PMPC_ST_IDLE = 4'h1,
    PMPC_ST_ADDR = 4'h2,
    PMPC_ST_STRB = 4'h4,
    PMPC_ST_DONE = 4'h8
  } pmpc_state_t;
endpackage

// ===== rtl/pmpc_cycle.sv
// read cycle sequencer of the parallel master port
// assumes one clock, synchronous active-high reset
`timescale 1ns/10ps
`include "pmpc_cfg.svh"
module pmpc_cycle
#(
  parameter int STROBE_CYC = `PMPC_STROBE_CYC
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic start,
  input wire logic run,
  input wire pmpc_pkg::pmpc_mux_t mux,
  output logic addr_phase,
  output logic strobe,
  output logic done
);
  import pmpc_pkg::*;
  pmpc_state_t state_reg;
  pmpc_state_t state_next;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  wire logic muxed;
  wire logic cnt_end;

  // address phase only when address shares data pins
  assign muxed = (mux != PMPC_MUX_NONE);
  assign cnt_end = (cnt_reg == 8'h00);

  // sequence: address phase, read strobe, done
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    if (!cnt_end)
    begin
      cnt_next = cnt_reg - 8'h01;
    end
    case (state_reg)
      PMPC_ST_IDLE:
      begin
        if (start)
        begin
          state_next = muxed ? PMPC_ST_ADDR : PMPC_ST_STRB;
          cnt_next = 8'(STROBE_CYC - 1);
        end
      end
      PMPC_ST_ADDR:
      begin
        state_next = PMPC_ST_STRB;
        cnt_next = 8'(STROBE_CYC - 1);
      end
      PMPC_ST_STRB:
      begin
        if (cnt_end)
        begin
          state_next = PMPC_ST_DONE;
        end
      end
      PMPC_ST_DONE:
      begin
        state_next = PMPC_ST_IDLE;
      end
      default:
      begin
        state_next = PMPC_ST_IDLE;
      end
    endcase
  end

  // state holds while halted in idle
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg <= PMPC_ST_IDLE;
      cnt_reg <= 8'h00;
    end
    else if (run)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  assign addr_phase = (state_reg == PMPC_ST_ADDR);
  assign strobe = (state_reg == PMPC_ST_STRB);
  assign done = (state_reg == PMPC_ST_DONE) && run;
endmodule

// ===== rtl/pmpc_top.sv
// control logic of the parallel master port, apb slave plus pin drive
// assumes apb master on clk_sys, synchronous active-high reset
//
// Functional notes
// - writing one to launch bit starts one read; hardware clears it after
// - split select one uses separate read/write buffers, zero shared ones; only the address buffer is shared, data stays separate
// - split select honoured only in master mode, ignored otherwise
// - enable zero disables port, no external access; one enables it
// - idle-halt one stops port in system idle; zero keeps running
// - mux 11 puts low eight address bits on sixteen data pins
// - mux 10 puts all sixteen address bits on the data pins
// - mux 01 low byte on data 7..0, high byte on address 15..8
// - mux 00 drives address and data on separate pins
// - write strobe pin driven only when its enable bit is one
// - read strobe pin driven only when its enable bit is one
// - select and latch polarity bits ignored where pins carry address
// - unimplemented control bits always read as zero
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "pmpc_cfg.svh"
module pmpc_top
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic master_mode,
  input wire logic sys_idle,
  input wire logic [15:0] port_data_pins_in,
  output logic [15:0] port_data_pins_out,
  output logic port_data_pins_oe,
  output logic [15:0] port_address_pins,
  output logic addr_latch_strobe,
  output logic first_select_pin,
  output logic read_or_direction_strobe_pin,
  output logic read_or_direction_strobe_oe,
  output logic write_strobe_or_enable_pin,
  output logic write_strobe_or_enable_oe
);
  import pmpc_pkg::*;

  // ****************************************
  // register file
  // ****************************************
  logic [31:0] port_control_reg;
  logic [31:0] port_control_next;
  logic [15:0] read_address_reg;
  logic [15:0] write_address_reg;
  logic [15:0] read_data_reg;
  logic [15:0] write_data_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pslverr_reg;
  logic pslverr_next;

  wire logic wr_acc;
  wire logic rd_acc;
  wire logic hit_ctrl;
  wire logic hit_raddr;
  wire logic hit_rdata;
  wire logic hit_waddr;
  wire logic hit_wdata;
  wire logic hit_any;
  wire logic ctl_on;
  wire logic ctl_split;
  wire logic ctl_idle;
  wire logic ctl_launch;
  wire logic ctl_wren;
  wire logic ctl_rden;
  wire logic ctl_alp;
  wire logic ctl_first_select_polarity;
  wire logic [1:0] ctl_csf;
  wire pmpc_mux_t ctl_mux;
  wire logic split_eff;
  wire logic run;
  wire logic cyc_addr;
  wire logic cyc_strobe;
  wire logic cyc_done;
  wire logic launch_set;
  wire logic [15:0] cur_addr;

  // apb access phase decode; pready rises in the second access cycle
  assign wr_acc = psel && penable && pwrite && !pready_reg;
  assign rd_acc = psel && penable && !pwrite && !pready_reg;
  assign hit_ctrl = (paddr == `PMPC_OFF_CTRL);
  assign hit_raddr = (paddr == `PMPC_OFF_RADDR);
  assign hit_rdata = (paddr == `PMPC_OFF_RDATA);
  assign hit_waddr = (paddr == `PMPC_OFF_WADDR);
  assign hit_wdata = (paddr == `PMPC_OFF_WDATA);
  assign hit_any = hit_ctrl || hit_raddr || hit_rdata || hit_waddr
                   || hit_wdata;

  // control fields
  assign ctl_on = port_control_reg[`PMPC_BIT_ON];
  assign ctl_split = port_control_reg[`PMPC_BIT_SPLIT];
  assign ctl_idle = port_control_reg[`PMPC_BIT_IDLE];
  assign ctl_launch = port_control_reg[`PMPC_BIT_LAUNCH];
  assign ctl_wren = port_control_reg[`PMPC_BIT_WREN];
  assign ctl_rden = port_control_reg[`PMPC_BIT_RDEN];
  assign ctl_csf = port_control_reg[7:6];
  assign ctl_alp = port_control_reg[5];
  assign ctl_first_select_polarity = port_control_reg[3];
  assign ctl_mux = pmpc_mux_t'(port_control_reg[`PMPC_MUX_HI:`PMPC_MUX_LO]);

  // split buffers only in master mode
  assign split_eff = ctl_split && master_mode;
  // enabled and not halted by idle
  assign run = ctl_on && !(ctl_idle && sys_idle);
  // read address: own register when split, shared otherwise
  assign cur_addr = split_eff ? read_address_reg : write_address_reg;
  // launch write of one sets the bit; zero has no effect
  assign launch_set = wr_acc && hit_ctrl && pwdata[`PMPC_BIT_LAUNCH];

  // control next value: hardware clear of launch, a write of one wins
  always_comb
  begin
    port_control_next = port_control_reg;
    if (cyc_done)
    begin
      port_control_next[`PMPC_BIT_LAUNCH] = 1'b0;
    end
    if (wr_acc && hit_ctrl)
    begin
      port_control_next = pwdata & `PMPC_CTRL_WMASK;
      port_control_next[`PMPC_BIT_LAUNCH] = launch_set
        || (ctl_launch && !cyc_done);
    end
  end

  // read mux; unimplemented bits zero
  always_comb
  begin
    prdata_next = 32'h0000_0000;
    if (hit_ctrl)
    begin
      prdata_next = port_control_reg;
    end
    else if (hit_raddr)
    begin
      prdata_next = {16'h0000, read_address_reg};
    end
    else if (hit_rdata)
    begin
      prdata_next = {16'h0000, read_data_reg};
    end
    else if (hit_waddr)
    begin
      prdata_next = {16'h0000, write_address_reg};
    end
    else if (hit_wdata)
    begin
      prdata_next = {16'h0000, write_data_reg};
    end
  end
  assign pslverr_next = (wr_acc || rd_acc) && !hit_any;

  // control and apb answer flops
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      port_control_reg <= `PMPC_CTRL_RESET;
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      port_control_reg <= port_control_next;
      prdata_reg <= rd_acc ? prdata_next : prdata_reg;
      pready_reg <= wr_acc || rd_acc;
      pslverr_reg <= pslverr_next;
    end
  end

  // address and data buffers; shared view aliases the write address register
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      read_address_reg <= 16'h0000;
      write_address_reg <= 16'h0000;
      write_data_reg <= 16'h0000;
      read_data_reg <= 16'h0000;
    end
    else
    begin
      if (wr_acc && hit_raddr)
        read_address_reg <= pwdata[15:0];
      if (wr_acc && hit_waddr)
        write_address_reg <= pwdata[15:0];
      if (wr_acc && hit_wdata)
        write_data_reg <= pwdata[15:0];
      if (cyc_done)
        read_data_reg <= port_data_pins_in; // captured at strobe end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  // ****************************************
  // read cycle sequencer
  // ****************************************
  pmpc_cycle u_cycle
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .start(ctl_launch && run),
    .run(run),
    .mux(ctl_mux),
    .addr_phase(cyc_addr),
    .strobe(cyc_strobe),
    .done(cyc_done)
  );

  // ****************************************
  // pin drive
  // ****************************************
  logic [15:0] dout_reg;
  logic [15:0] dout_next;
  logic doe_reg;
  logic [15:0] aout_reg;
  logic [15:0] aout_next;
  logic ale_reg;
  logic cs1_reg;
  logic cs1_next;
  logic rd_reg;
  logic rdoe_reg;
  logic wr_reg;
  logic wroe_reg;
  wire logic cs1_is_addr;

  // first select pin carries address pin bit 14 when function field is 0 or mux is 01
  assign cs1_is_addr = (ctl_csf == 2'h0)
                       || (ctl_mux == PMPC_MUX_LOW8);

  // address/data placement per multiplex scheme
  always_comb
  begin
    dout_next = 16'h0000;
    aout_next = cur_addr;
    case (ctl_mux)
      PMPC_MUX_LOW8_WIDE:
      begin
        dout_next = {8'h00, cur_addr[7:0]};
        aout_next = 16'h0000;
      end
      PMPC_MUX_ALL16:
      begin
        dout_next = cur_addr;
        aout_next = 16'h0000;
      end
      PMPC_MUX_LOW8:
      begin
        dout_next = {8'h00, cur_addr[7:0]};
        aout_next = {cur_addr[15:8], 8'h00};
      end
      default:
      begin
        dout_next = 16'h0000;
        aout_next = cur_addr;
      end
    endcase
    cs1_next = cs1_is_addr ? aout_next[14]
               : (cyc_strobe ~^ ctl_first_select_polarity);
  end

  // pin flops; address, select and output enables forced low while disabled, latch and read strobe not
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      dout_reg <= 16'h0000;
      doe_reg <= 1'b0;
      aout_reg <= 16'h0000;
      ale_reg <= 1'b0;
      cs1_reg <= 1'b0;
      rd_reg <= 1'b0;
      rdoe_reg <= 1'b0;
      wr_reg <= 1'b0;
      wroe_reg <= 1'b0;
    end
    else
    begin
      dout_reg <= cyc_addr ? dout_next : 16'h0000;
      doe_reg <= run && cyc_addr;
      aout_reg <= ctl_on ? aout_next : 16'h0000;
      ale_reg <= cs1_is_addr ? 1'b0 : (cyc_addr ~^ ctl_alp);
      cs1_reg <= ctl_on ? cs1_next : 1'b0;
      rd_reg <= cyc_strobe;
      rdoe_reg <= ctl_on && ctl_rden;
      wr_reg <= 1'b0;
      wroe_reg <= ctl_on && ctl_wren;
    end
  end

  assign port_data_pins_out = dout_reg;
  assign port_data_pins_oe = doe_reg;
  assign port_address_pins = aout_reg;
  assign addr_latch_strobe = ale_reg;
  assign first_select_pin = cs1_reg;
  assign read_or_direction_strobe_pin = rd_reg;
  assign read_or_direction_strobe_oe = rdoe_reg;
  assign write_strobe_or_enable_pin = wr_reg;
  assign write_strobe_or_enable_oe = wroe_reg;

  // ****************************************
  // checks
  // ****************************************
  default clocking chk_cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  AST_LAUNCH_CLEARS: assert property (
    (cyc_done && !launch_set) |=> !ctl_launch)
    else $error("launch bit not cleared after read");
  AST_NO_START_OFF: assert property (
    !ctl_on |=> !cyc_strobe || $past(cyc_strobe))
    else $error("read started while disabled");
  AST_IDLE_HALT: assert property (
    (ctl_idle && sys_idle) |=> $stable({cyc_addr, cyc_strobe}))
    else $error("port moved while halted in idle");
  AST_SPLIT_MASTER: assert property (
    (!master_mode && ctl_on && ctl_mux == PMPC_MUX_NONE)
      |=> port_address_pins == $past(write_address_reg))
    else $error("split buffers outside master mode");
  AST_RDEN: assert property (
    !ctl_rden |=> !read_or_direction_strobe_oe)
    else $error("read strobe driven while disabled");
  AST_WREN: assert property (
    !ctl_wren |=> !write_strobe_or_enable_oe)
    else $error("write strobe driven while disabled");
  AST_RESERVED_ZERO: assert property (
    (port_control_reg & ~(`PMPC_CTRL_WMASK | 32'h0080_0000))
      == 32'h0000_0000)
    else $error("reserved control bit set");
  AST_MUX_HIGH_ZERO: assert property (
    (cyc_addr && ctl_mux == PMPC_MUX_LOW8_WIDE)
      |=> port_data_pins_out[15:8] == 8'h00)
    else $error("upper address byte on data pins");
  AST_MUX_ALL16: assert property (
    (cyc_addr && ctl_mux == PMPC_MUX_ALL16)
      |=> port_data_pins_out == $past(cur_addr))
    else $error("full address not on data pins");
  AST_SEPARATE: assert property (
    (ctl_on && ctl_mux == PMPC_MUX_NONE) |=> !port_data_pins_oe)
    else $error("data pins driven in separate mode");
  AST_RESET_OFF: assert property (
    $past(rst) |-> port_control_reg == 32'h0000_0000)
    else $error("control not cleared by reset");
  AST_MUX01_HIGH: assert property (
    (ctl_on && ctl_mux == PMPC_MUX_LOW8)
      |=> port_address_pins[15:8] == $past(cur_addr[15:8]))
    else $error("upper address not on address pins");
endmodule

// ===== verification/pmpc_periph_model.sv
// model of the external peripheral on the port pins
// assumes pin enables from the port and one clock
`timescale 1ns/10ps
module pmpc_periph_model
#(
  parameter logic [15:0] RD_VAL = 16'h5ac3,
  parameter int LAT = 0
)
(
  input wire logic clk_sys,
  input wire logic strobe,
  input wire logic strobe_oe,
  input wire logic port_oe,
  output logic [15:0] data_out
);
  int wait_cnt = 0;
  // ****************
  // read response
  // ****************
  // cycles the read strobe has been active with the bus free
  always @(posedge clk_sys)
  begin
    if (strobe && strobe_oe && !port_oe)
      wait_cnt <= wait_cnt + 1;
    else
      wait_cnt <= 0;
  end
  // a released bus shows the inverse, never a stale copy
  assign data_out = (strobe && strobe_oe && !port_oe && wait_cnt >= LAT) ?
                    RD_VAL : ~RD_VAL;
endmodule

// ===== verification/pmpc_top_tb_top.sv
// testbench of the parallel master port control block
// assumes the cfg header on the include path, apb at 10 mhz
`timescale 1ns/10ps
`include "pmpc_cfg.svh"
module pmpc_top_tb_top;
  localparam logic [31:0] on_b = 32'h0000_8000;
  localparam logic [31:0] spl_b = 32'h0002_0000;
  localparam logic [31:0] go_b = 32'h0080_0000;
  localparam logic [31:0] we_b = 32'h0000_0200;
  localparam logic [31:0] re_b = 32'h0000_0100;
  localparam logic [31:0] ih_b = 32'h0000_2000;
  localparam logic [31:0] m2_b = 32'h0000_1000;
  localparam logic [15:0] rd_val = 16'h5ac3;
  logic clk_sys, rst, psel, penable, pwrite, master_mode, sys_idle;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, cw;
  logic pready, pslverr, serr, pd_oe, cs1, rs_oe, ws_oe, clr, rs_seen;
  logic rs_pin, ws_pin, ale;
  logic [15:0] pd_in, pd_out, pa, periph_d, ad_val;
  int err_total, tests_run, cyc, ad_cnt;
  pmpc_top pmpc_top_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .master_mode(master_mode), .sys_idle(sys_idle),
    .port_data_pins_in(pd_in), .port_data_pins_out(pd_out),
    .port_data_pins_oe(pd_oe), .port_address_pins(pa),
    .addr_latch_strobe(ale), .first_select_pin(cs1),
    .read_or_direction_strobe_pin(rs_pin),
    .read_or_direction_strobe_oe(rs_oe),
    .write_strobe_or_enable_pin(ws_pin),
    .write_strobe_or_enable_oe(ws_oe));
  pmpc_periph_model pmpc_periph_model_i (.clk_sys(clk_sys),
    .strobe(rs_pin), .strobe_oe(rs_oe), .port_oe(pd_oe),
    .data_out(periph_d));
  // wire level seen by the port
  assign pd_in = pd_oe ? pd_out : periph_d;
  // ****************
  // clock and monitor
  // ****************
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // record address phases and enabled read strobe pulses per read cycle
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (clr)
    begin
      ad_cnt <= 0;
      rs_seen <= 1'b0;
    end
    else
    begin
      if (pd_oe)
      begin
        ad_cnt <= ad_cnt + 1;
        ad_val <= pd_out;
      end
      if (rs_oe && rs_pin)
        rs_seen <= 1'b1;
    end
    if (cyc == 20000)
    begin
      err_total++;
      $display("[FAIL] %0t run timed out", $time);
      test_done();
    end
  end
  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, request held until pready
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clk_sys);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(pready), 32'h1);
  endtask
  task automatic go(input logic [31:0] c);
    @(posedge clk_sys);
    clr <= 1'b1;
    @(posedge clk_sys);
    clr <= 1'b0;
    apb(1'b1, `PMPC_OFF_CTRL, c);
  endtask
  // wait for the cycle to end, then judge the pins
  task automatic fin(input logic [31:0] c, input logic [15:0] ea);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `PMPC_OFF_CTRL, 32'h0);
      n++;
    end
    while (q[23] !== 1'b0 && n < 30);
    chk(32'(q[23]), 32'h0);
    chk(32'(ad_cnt != 0), 32'(c[12:11] != 2'h0));
    case (c[12:11])
      2'h3: chk(32'(ad_val), 32'(ea[7:0]));
      2'h2: chk(32'(ad_val), 32'(ea));
      2'h1:
      begin
        chk(32'(ad_val[7:0]), 32'(ea[7:0]));
        chk(32'(pa[15:8]), 32'(ea[15:8]));
      end
      default:
      begin
        chk(32'(pa), 32'(ea));
        chk(32'(cs1), 32'(ea[14]));
      end
    endcase
    chk(32'(rs_seen), 32'(c[8]));
    chk(32'(ws_oe), 32'(c[9]));
    chk(32'(ws_pin), 32'h0);
    chk(32'(ale), 32'h0);
    if (c[8])
    begin
      apb(1'b0, `PMPC_OFF_RDATA, 32'h0);
      chk(q, {16'h0, rd_val});
    end
  endtask
  // launch that must stay pending with no bus activity
  task automatic hold(input logic [31:0] c);
    go(c);
    repeat (10) @(posedge clk_sys);
    apb(1'b0, `PMPC_OFF_CTRL, 32'h0);
    chk(32'(q[23]), 32'h1);
    chk(32'(ad_cnt), 32'h0);
  endtask
  task automatic test_done();
    if (err_total == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    {rst, master_mode} = 2'b11;
    {psel, penable, pwrite, sys_idle, clr, rs_seen} = 6'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ad_val = 16'h0;
    {err_total, tests_run, cyc, ad_cnt} = {4{32'sd0}};
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, `PMPC_OFF_CTRL, 32'h0);
    chk(q, 32'h0);
    chk(32'({pd_oe, rs_oe, ws_oe}), 32'h0);
    apb(1'b1, `PMPC_OFF_CTRL, 32'hff7f_7fff);
    apb(1'b0, `PMPC_OFF_CTRL, 32'h0);
    chk(q, 32'h0002_3ffb);
    apb(1'b0, 12'h100, 32'h0);
    chk({q[30:0], serr}, 32'h1);
    apb(1'b1, `PMPC_OFF_RADDR, 32'hffff_a55a);
    apb(1'b0, `PMPC_OFF_RADDR, 32'h0);
    chk(q, 32'h0000_a55a);
    apb(1'b1, `PMPC_OFF_WADDR, 32'h0000_3c96);
    for (int m = 0; m < 4; m++)
    begin
      cw = on_b | spl_b | we_b | re_b | 32'h8 | go_b | (32'(m) << 11);
      go(cw);
      fin(cw, 16'ha55a);
    end
    cw = on_b | we_b | re_b | go_b;
    go(cw);
    fin(cw, 16'h3c96);
    master_mode <= 1'b0;
    cw = on_b | spl_b | we_b | re_b | go_b;
    go(cw);
    fin(cw, 16'h3c96);
    master_mode <= 1'b1;
    cw = on_b | spl_b | m2_b | we_b | go_b;
    go(cw);
    fin(cw, 16'ha55a);
    cw = on_b | spl_b | m2_b | re_b | go_b;
    go(cw);
    fin(cw, 16'ha55a);
    hold(spl_b | m2_b | we_b | re_b | go_b);
    cw = on_b | spl_b | m2_b | we_b | re_b;
    go(cw);
    fin(cw, 16'ha55a);
    sys_idle <= 1'b1;
    hold(cw | ih_b | go_b);
    sys_idle <= 1'b0;
    fin(cw, 16'ha55a);
    sys_idle <= 1'b1;
    go(cw | go_b);
    fin(cw, 16'ha55a);
    sys_idle <= 1'b0;
    test_done();
  end
endmodule
